// ===== rtl/sct_pkg.sv
/*
 * Shared constants and types of the serial transmit/receive core: the register map, the
 * field positions, the reset values, the oversampling counts, the states and carriers.
 * Assumes a byte-wide register port and a 16x baud tick from an external generator.
 */
package sct_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [2:0] SCT_ADDR_TX_CTRL = 3'h0;
	localparam logic [2:0] SCT_ADDR_RX_CTRL = 3'h1;
	localparam logic [2:0] SCT_ADDR_TX_HOLD = 3'h2;
	localparam logic [2:0] SCT_ADDR_RX_DATA = 3'h3;
	localparam logic [2:0] SCT_ADDR_IRQ_FLAG = 3'h4;
	localparam logic [2:0] SCT_ADDR_IRQ_EN = 3'h5;
	localparam logic [2:0] SCT_ADDR_IRQ_GATE = 3'h6;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int SCT_TXC_SHIFTER_EMPTY = 0;
	localparam int SCT_TXC_NINTH_BIT = 1;
	localparam int SCT_TXC_NINE_SEL = 2;
	localparam int SCT_TXC_ENABLE = 3;
	localparam int SCT_TXC_POLARITY = 4;
	localparam int SCT_RXC_NINTH_BIT = 0;
	localparam int SCT_RXC_OVERRUN = 1;
	localparam int SCT_RXC_FRAMING = 2;
	localparam int SCT_RXC_NINE_SEL = 3;
	localparam int SCT_RXC_CONT_EN = 4;
	localparam int SCT_RXC_PORT_EN = 7;
	localparam int SCT_IRQ_TX = 0;
	localparam int SCT_IRQ_RX = 1;
	localparam int SCT_GATE_PERIPHERAL = 0;
	localparam int SCT_GATE_GLOBAL = 1;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [7:0] SCT_TXC_RESET = 8'h00;
	localparam logic [7:0] SCT_RXC_RESET = 8'h00;
	localparam logic [7:0] SCT_IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] SCT_IRQ_GATE_RESET = 8'h00;

	// ********************************************************
	// Bit timing in 16x ticks
	// ********************************************************
	localparam logic [3:0] SCT_TICK_LAST = 4'hF;
	localparam logic [3:0] SCT_TICK_SAMPLE_A = 4'h7;
	localparam logic [3:0] SCT_TICK_SAMPLE_B = 4'h8;
	localparam logic [3:0] SCT_TICK_DECIDE = 4'h9;
	localparam logic [3:0] SCT_LAST_BIT_EIGHT = 4'h7;
	localparam logic [3:0] SCT_LAST_BIT_NINE = 4'h8;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} sct_bus_req_t;

	typedef struct packed {
		logic framingErr;
		logic [8:0] data;
	} sct_rx_entry_t;

	typedef enum logic [1:0] {
		SCT_TX_IDLE = 2'b00,
		SCT_TX_START = 2'b01,
		SCT_TX_DATA = 2'b10,
		SCT_TX_STOP = 2'b11
	} sct_tx_state_t;

	typedef enum logic [1:0] {
		SCT_RX_IDLE = 2'b00,
		SCT_RX_START = 2'b01,
		SCT_RX_DATA = 2'b10,
		SCT_RX_STOP = 2'b11
	} sct_rx_state_t;

endpackage : sct_pkg

// ===== rtl/sct_rx_fifo.sv
/*
 * Two-entry receive buffer holding each character with its framing error indicator.
 * Assumes the caller never writes when full without a read, nor reads when empty.
 */
`timescale 1ns/1ps

module sct_rx_fifo import sct_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic wrEn,
	input wire sct_rx_entry_t wrEntry,
	input wire logic rdEn,
	output sct_rx_entry_t headEntry,
	output logic full,
	output logic empty
);

	sct_rx_entry_t slot [0:1];
	logic [1:0] count;
	logic wrPtr;
	logic rdPtr;

	always_ff @(posedge clk) begin
		if (!reset_n || flush) begin
			count <= 2'h0;
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
		end else begin
			if (wrEn) begin
				wrPtr <= ~wrPtr;
			end
			if (rdEn) begin
				rdPtr <= ~rdPtr;
			end
			count <= count + {1'b0, wrEn} - {1'b0, rdEn};
		end
	end

	// The slots need no reset; the count alone says which of them are valid.
	always_ff @(posedge clk) begin
		if (wrEn) begin
			slot[wrPtr] <= wrEntry;
		end
	end

	assign headEntry = slot[rdPtr];
	assign full = (count == 2'h2);
	assign empty = (count == 2'h0);

endmodule : sct_rx_fifo

// ===== rtl/sct_serial_core.sv
/*
 * Asynchronous serial core: transmit holding register, shifter and status flags, and the
 * 16x oversampled receiver with its two-entry buffer and error flags.
 * Assumes a single clock, a one-cycle 16x baud tick from an outside generator on the same
 * clock, and a serial input pin that is asynchronous to the clock.
 */
// Function
// - Transmit flag is set when enabled and the holding register is empty.
// - Transmit flag shows the new state from the second cycle after a write.
// - Transmit flag is read-only; writes do not change it.
// - Transmit flag ignores its enable; the enable only gates the request.
// - Shifter-empty status clears on load, stays clear until all bits leave.
// - Shifter-empty status is read-only, polled, raises no request.
// - Nine-bit mode shifts nine bits, ninth written bit is the MSB.
// - Ninth bit written first; all nine bits move to the shifter together.
// - Setting transmitter enable sets the flag; gated request follows one cycle later.
// - Software configures, then writes the holding register to start sending.
// - Receive line sampled at 16x baud; receive shifter advances per bit.
// - Completed characters enter a two-entry buffer.
// - Start bit not low at half time is dropped silently.
// - Each bit is taken one bit time apart by majority vote.
// - Low stop bit sets the character's framing error, high clears it.
// - At the stop bit centre the character is pushed and the flag set.
// - Reading receive data returns and removes the oldest character.
// - While overrun stands, no further characters are accepted.
// - Receive flag high when enabled with unread data; read-only.
// - Receive request needs its enable and both global gates.
// - Least significant data bit first on the line, both directions.
// - Frame is low start, eight or nine data, high stop; idle high; transmit polarity inverts the output pin.
// - Waiting character enters the shifter one cycle after the stop bit.
// - Third character into a full buffer sets overrun; enables clear it.
`timescale 1ns/1ps

module sct_serial_core import sct_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire sct_bus_req_t busReq,
	output logic [7:0] rdData,
	input wire logic baudTick16,
	input wire logic serialInputPin,
	output logic serialOutput,
	output logic serialOutputEnable,
	output logic txIrq,
	output logic rxIrq
);

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic isWrite(input sct_bus_req_t r, input logic [2:0] a);
		return r.wrStrobe && (r.addr == a);
	endfunction : isWrite

	function automatic logic isRead(input sct_bus_req_t r, input logic [2:0] a);
		return r.rdStrobe && (r.addr == a);
	endfunction : isRead

	function automatic logic [3:0] lastBit(input logic nine);
		return nine ? SCT_LAST_BIT_NINE : SCT_LAST_BIT_EIGHT;
	endfunction : lastBit

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction : maj3

	// ********************************************************
	// Control registers
	// ********************************************************
	logic txNinth;
	logic txNineSel;
	logic txEnable;
	logic txPol;
	logic rxNineSel;
	logic rxContEnable;
	logic portEnable;
	logic txIe;
	logic rxIe;
	logic periGate;
	logic globGate;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			{txPol, txEnable, txNineSel, txNinth} <= SCT_TXC_RESET[4:1];
			{rxContEnable, rxNineSel} <= SCT_RXC_RESET[4:3];
			portEnable <= SCT_RXC_RESET[SCT_RXC_PORT_EN];
			{rxIe, txIe} <= SCT_IRQ_EN_RESET[1:0];
			{globGate, periGate} <= SCT_IRQ_GATE_RESET[1:0];
		end else if (isWrite(busReq, SCT_ADDR_TX_CTRL)) begin
			txNinth <= busReq.wrData[SCT_TXC_NINTH_BIT];
			txNineSel <= busReq.wrData[SCT_TXC_NINE_SEL];
			txEnable <= busReq.wrData[SCT_TXC_ENABLE];
			txPol <= busReq.wrData[SCT_TXC_POLARITY];
		end else if (isWrite(busReq, SCT_ADDR_RX_CTRL)) begin
			rxNineSel <= busReq.wrData[SCT_RXC_NINE_SEL];
			rxContEnable <= busReq.wrData[SCT_RXC_CONT_EN];
			portEnable <= busReq.wrData[SCT_RXC_PORT_EN];
		end else if (isWrite(busReq, SCT_ADDR_IRQ_EN)) begin
			txIe <= busReq.wrData[SCT_IRQ_TX];
			rxIe <= busReq.wrData[SCT_IRQ_RX];
		end else if (isWrite(busReq, SCT_ADDR_IRQ_GATE)) begin
			periGate <= busReq.wrData[SCT_GATE_PERIPHERAL];
			globGate <= busReq.wrData[SCT_GATE_GLOBAL];
		end
	end

	// ********************************************************
	// Transmit holding register
	// ********************************************************
	logic [8:0] holdData;
	logic holdFull;
	logic [8:0] shiftReg;
	sct_tx_state_t txState;
	logic [3:0] txTick;
	logic [3:0] txBit;
	logic txFlag;
	logic txActive;
	logic loadShifter;
	logic shifterEmpty;
	logic txLine;

	assign txActive = txEnable && portEnable;
	assign loadShifter = txActive && holdFull && (txState == SCT_TX_IDLE);
	// the status follows the shifter alone.
	assign shifterEmpty = (txState == SCT_TX_IDLE);

	// A write over a still-full holding register replaces the queued character.
	always_ff @(posedge clk) begin
		if (!reset_n || !txActive) begin
			holdFull <= 1'b0;
			holdData <= 9'h000;
		end else if (isWrite(busReq, SCT_ADDR_TX_HOLD)) begin
			// a holding write queues the character that starts the frame.
			// ninth bit joins the byte as the MSB in nine-bit mode.
			// ninth bit is taken as already written.
			holdData <= {txNinth & txNineSel, busReq.wrData};
			holdFull <= 1'b1;
		end else if (loadShifter) begin
			holdFull <= 1'b0;
		end
	end

	// flag tracks enable and holding state.
	// registered from the next holding state, valid two cycles after a write.
	// Taking the next state keeps an idle shifter's load from showing a false busy cycle.
	// no bus write reaches this flag.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			txFlag <= 1'b0;
		end else begin
			txFlag <= txEnable && !(holdFull && !loadShifter);
		end
	end

	// ********************************************************
	// Transmit shifter
	// ********************************************************
	// every bit lasts sixteen outside ticks.
	always_ff @(posedge clk) begin
		if (!reset_n || !txActive) begin
			txState <= SCT_TX_IDLE;
			shiftReg <= 9'h000;
			txTick <= 4'h0;
			txBit <= 4'h0;
		end else begin
			case (txState)
				SCT_TX_IDLE: begin
					// queued character loads in the cycle after the stop bit.
					if (loadShifter) begin
						shiftReg <= holdData;
						txTick <= 4'h0;
						txState <= SCT_TX_START;
					end
				end
				default: begin
					if (baudTick16) begin
						txTick <= txTick + 4'h1;
						if (txTick == SCT_TICK_LAST) begin
							case (txState)
								SCT_TX_START: begin
									txBit <= 4'h0;
									txState <= SCT_TX_DATA;
								end
								SCT_TX_DATA: begin
									shiftReg <= {1'b0, shiftReg[8:1]};
									txBit <= txBit + 4'h1;
									// nine bits per frame when selected.
									if (txBit == lastBit(txNineSel)) begin
										txState <= SCT_TX_STOP;
									end
								end
								default: begin
									txState <= SCT_TX_IDLE;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// start low, data, stop and idle high.
	always_comb begin
		case (txState)
			SCT_TX_START: txLine = 1'b0;
			SCT_TX_DATA: txLine = shiftReg[0];
			default: txLine = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			serialOutput <= 1'b1;
			serialOutputEnable <= 1'b0;
		end else begin
			serialOutput <= txLine ^ txPol;
			serialOutputEnable <= portEnable;
		end
	end

	// ********************************************************
	// Receive recovery
	// ********************************************************
	logic rxSync1;
	logic rxSync2;
	logic rxPrev;
	sct_rx_state_t rxState;
	logic [3:0] rxTick;
	logic [3:0] rxBit;
	logic [8:0] rxShift;
	logic [1:0] rxSamples;
	logic rxActive;
	logic rxDecide;
	logic rxBitVal;
	logic push;
	sct_rx_entry_t pushEntry;
	logic rxOverrun;
	logic pop;
	logic fifoFull;
	logic fifoEmpty;
	logic fifoWrite;
	sct_rx_entry_t headEntry;
	logic rxFlag;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rxSync1 <= 1'b1;
			rxSync2 <= 1'b1;
			rxPrev <= 1'b1;
		end else begin
			rxSync1 <= serialInputPin;
			rxSync2 <= rxSync1;
			rxPrev <= rxSync2;
		end
	end

	assign rxActive = rxContEnable && portEnable;
	assign rxDecide = baudTick16 && (rxTick == SCT_TICK_DECIDE);
	// two earlier samples and the present one vote.
	assign rxBitVal = maj3(rxSamples[1], rxSamples[0], rxSync2);

	// the bit clock is the 16x tick counted to sixteen.
	always_ff @(posedge clk) begin
		if (!reset_n || !rxActive) begin
			rxState <= SCT_RX_IDLE;
			rxTick <= 4'h0;
			rxBit <= 4'h0;
			rxShift <= 9'h000;
			rxSamples <= 2'h3;
			push <= 1'b0;
			pushEntry <= '0;
		end else begin
			push <= 1'b0;
			if (rxState == SCT_RX_IDLE) begin
				// no new start edge is taken while overrun stands.
				if (rxPrev && !rxSync2 && !rxOverrun) begin
					rxTick <= 4'h0;
					rxState <= SCT_RX_START;
				end
			end else if (baudTick16) begin
				rxTick <= rxTick + 4'h1;
				if (rxTick == SCT_TICK_SAMPLE_A || rxTick == SCT_TICK_SAMPLE_B) begin
					rxSamples <= {rxSamples[0], rxSync2};
				end
				if (rxDecide) begin
					case (rxState)
						SCT_RX_START: begin
							// a high start centre drops back to idle silently.
							if (rxBitVal) begin
								rxState <= SCT_RX_IDLE;
							end else begin
								rxBit <= 4'h0;
								rxShift <= 9'h000;
								rxState <= SCT_RX_DATA;
							end
						end
						SCT_RX_DATA: begin
							// first data bit lands in bit zero.
							rxShift[rxBit] <= rxBitVal;
							rxBit <= rxBit + 4'h1;
							if (rxBit == lastBit(rxNineSel)) begin
								rxState <= SCT_RX_STOP;
							end
						end
						default: begin
							// low stop level marks a framing error.
							// character is handed over at the stop bit's centre decision.
							pushEntry <= '{framingErr: ~rxBitVal, data: rxShift};
							push <= 1'b1;
							rxState <= SCT_RX_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ********************************************************
	// Receive buffer and flags
	// ********************************************************
	// a read of receive data pops the oldest character.
	assign pop = isRead(busReq, SCT_ADDR_RX_DATA) && !fifoEmpty;
	assign fifoWrite = push && (!fifoFull || pop);

	// two characters are held; a third may be on its way.
	sct_rx_fifo u_rx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.flush(!portEnable),
		.wrEn(fifoWrite),
		.wrEntry(pushEntry),
		.rdEn(pop),
		.headEntry(headEntry),
		.full(fifoFull),
		.empty(fifoEmpty)
	);

	// a complete third character into a full buffer sets overrun.
	always_ff @(posedge clk) begin
		if (!reset_n || !rxActive) begin
			rxOverrun <= 1'b0;
		end else if (push && !fifoWrite) begin
			rxOverrun <= 1'b1;
		end
	end

	// flag needs the receiver enabled and an unread character.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rxFlag <= 1'b0;
		end else begin
			rxFlag <= rxActive && !fifoEmpty;
		end
	end

	// enables gate only the requests, not the flags.
	// the request follows the flag in the next cycle.
	// receive request needs all three enables.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			txIrq <= 1'b0;
			rxIrq <= 1'b0;
		end else begin
			txIrq <= txFlag && txIe && periGate && globGate;
			rxIrq <= rxFlag && rxIe && periGate && globGate;
		end
	end

	// ********************************************************
	// Read port
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!reset_n || !busReq.rdStrobe) begin
			rdData <= 8'h00;
		end else if (busReq.addr == SCT_ADDR_TX_CTRL) begin
			rdData <= {3'h0, txPol, txEnable, txNineSel, txNinth, shifterEmpty};
		end else if (busReq.addr == SCT_ADDR_RX_CTRL) begin
			rdData <= {portEnable, 2'h0, rxContEnable, rxNineSel,
				headEntry.framingErr & !fifoEmpty, rxOverrun, headEntry.data[8] & !fifoEmpty};
		end else if (busReq.addr == SCT_ADDR_RX_DATA) begin
			rdData <= fifoEmpty ? 8'h00 : headEntry.data[7:0];
		end else if (busReq.addr == SCT_ADDR_IRQ_FLAG) begin
			rdData <= {6'h00, rxFlag, txFlag};
		end else if (busReq.addr == SCT_ADDR_IRQ_EN) begin
			rdData <= {6'h00, rxIe, txIe};
		end else if (busReq.addr == SCT_ADDR_IRQ_GATE) begin
			rdData <= {6'h00, globGate, periGate};
		end else begin
			rdData <= 8'h00;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_tx_flag_late: assert property (
		(isWrite(busReq, SCT_ADDR_TX_HOLD) && txActive && !holdFull
		&& (txState == SCT_TX_START || txState == SCT_TX_DATA))
		|-> ##1 txFlag ##1 !txFlag) else $error("transmit flag timing after write wrong");
	a_tx_enable_flag: assert property (
		($rose(txEnable) && !holdFull) |=> txFlag) else $error("enable did not set flag");
	a_tx_irq_gate: assert property (
		txIrq |-> $past(txFlag && txIe && periGate && globGate))
		else $error("transmit request without its enables");
	a_shift_busy: assert property (
		$fell(shifterEmpty) |-> $past(holdFull)) else $error("shifter busy without a load");
	a_tx_start_low: assert property (
		(txState == SCT_TX_START) |=> (serialOutput == $past(txPol)))
		else $error("start bit not low");
	a_tx_handoff: assert property (
		(txState == SCT_TX_STOP && baudTick16 && txTick == SCT_TICK_LAST && holdFull
		&& txActive) |=> (txActive |-> ##1 txState == SCT_TX_START))
		else $error("queued character not loaded after stop");
	a_rx_abort: assert property (
		(rxState == SCT_RX_START && rxDecide && rxBitVal && rxActive)
		|=> (rxState == SCT_RX_IDLE && !push) ##1 !push) else $error("false start not dropped");
	a_rx_push_flag: assert property (
		(push && !fifoFull && rxActive) |=> (rxActive |-> ##1 rxFlag))
		else $error("receive flag not set after push");
	a_rx_pop_fifo: assert property (
		(pop && fifoFull && !push) |=> !fifoFull) else $error("read did not remove character");
	a_overrun_set: assert property (
		(push && fifoFull && !pop && rxActive) |=> rxOverrun) else $error("overrun not flagged");
	a_overrun_hold: assert property (
		(rxOverrun && rxState == SCT_RX_IDLE && rxActive) |=> rxState == SCT_RX_IDLE)
		else $error("reception started during overrun");
	a_rx_irq_gate: assert property (
		rxIrq |-> $past(rxFlag && rxIe && periGate && globGate))
		else $error("receive request without its enables");

	c_rx_round_trip: cover property (push ##[1:40] pop);
	c_rx_overrun: cover property ($rose(rxOverrun));
	c_tx_back_to_back: cover property (
		txState == SCT_TX_STOP ##1 txState == SCT_TX_IDLE ##1 txState == SCT_TX_START);
	c_rx_false_start: cover property (rxState == SCT_RX_START && rxDecide && rxBitVal);

endmodule : sct_serial_core

// ===== sim/sct_peer.sv
/*
 * Remote serial transceiver: sends frames into the core and decodes the frames it sends.
 * Assumes the bench supplies the 16x baud tick on the system clock and polarity 0.
 */
`timescale 1ns/1ps

module sct_peer (
	input wire logic clk,
	input wire logic baudTick16,
	input wire logic nineMode,
	input wire logic txLine,
	output logic rxLine
);
	logic [8:0] got[$];
	logic [8:0] shiftIn;

	initial begin
		rxLine = 1'b1;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge clk iff baudTick16);
	endtask : ticks

	// low start, lsb first, stop, idle
	task automatic send(input logic [8:0] v, input int nb, input logic stopLvl);
		ticks(1);
		rxLine <= 1'b0;
		ticks(16);
		for (int i = 0; i < nb; i++) begin
			rxLine <= v[i];
			ticks(16);
		end
		rxLine <= stopLvl;
		ticks(16);
		rxLine <= 1'b1;
		ticks(24);
	endtask : send

	// start too short to survive the centre check
	task automatic glitch();
		ticks(1);
		rxLine <= 1'b0;
		ticks(4);
		rxLine <= 1'b1;
		ticks(40);
	endtask : glitch

	// bit centres; a low stop bit is logged as unknown
	initial begin
		forever begin
			@(negedge txLine);
			ticks(8);
			if (txLine === 1'b0) begin
				shiftIn = '0;
				for (int i = 0; i < (nineMode ? 9 : 8); i++) begin
					ticks(16);
					shiftIn[i] = txLine;
				end
				ticks(16);
				got.push_back(txLine === 1'b1 ? shiftIn : 'x);
			end
		end
	end
endmodule : sct_peer

// ===== sim/tb.sv
/*
 * Self-checking bench of the serial core: register port master, baud tick, peer model.
 * Assumes the register map and field positions of the package.
 */
`timescale 1ns/1ps

module tb import sct_pkg::*; ;
	logic clk;
	logic reset_n;
	sct_bus_req_t busReq;
	logic [7:0] rdData;
	logic baudTick16 = 1'b0;
	logic serialOutput, serialOutputEnable, txIrq, rxIrq, rxLine;
	logic nineMode = 1'b0;
	logic [1:0] divCnt = 2'h0;
	int cyc, fails, checked;
	bit ovr;
	logic [8:0] expTx[$];
	logic [9:0] expRx[$];
	logic [7:0] b;

	sct_serial_core u_dut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
		.baudTick16(baudTick16), .serialInputPin(rxLine), .serialOutput(serialOutput),
		.serialOutputEnable(serialOutputEnable), .txIrq(txIrq), .rxIrq(rxIrq));
	sct_peer u_peer (.clk(clk), .baudTick16(baudTick16), .nineMode(nineMode),
		.txLine(serialOutput), .rxLine(rxLine));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ********************************************************
	// Baud tick and hang guard
	// ********************************************************
	// A short divider keeps frames at 64 clocks per bit.
	always @(posedge clk) begin
		divCnt <= divCnt + 2'h1;
		baudTick16 <= (divCnt == 2'h3);
		cyc++;
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic bad(input string m);
		fails++;
		$display("Error %0t: %s", $time, m);
	endtask : bad

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= {a, d, 2'b10};
		@(posedge clk);
		busReq <= '0;
		#1;
	endtask : wr

	task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		busReq <= {a, 8'h00, 2'b01};
		@(posedge clk);
		busReq <= '0;
		#1;
		checked++;
		if (rdData !== e) bad($sformatf("reg %0d got %h exp %h", a, rdData, e));
	endtask : rdChk

	task automatic cmpPin(input logic g, input logic e);
		checked++;
		if (g !== e) bad($sformatf("pin got %b exp %b", g, e));
	endtask : cmpPin

	task automatic cmpSer(input logic [8:0] g, input logic [8:0] e);
		checked++;
		if (g !== e) bad($sformatf("char got %h exp %h", g, e));
	endtask : cmpSer

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic waitGot(input int n);
		repeat (8000) if (u_peer.got.size() < n) @(posedge clk);
		step(80);
	endtask : waitGot

	// Model of the receive buffer: two entries, then overrun locks it.
	task automatic peerSend(input logic [8:0] v, input logic stopLvl);
		u_peer.send(v, nineMode ? 9 : 8, stopLvl);
		if (!ovr && expRx.size() < 2) expRx.push_back({~stopLvl, v});
		else ovr = 1'b1;
	endtask : peerSend

	task automatic popChk();
		logic [9:0] e;
		e = expRx.pop_front();
		rdChk(SCT_ADDR_RX_CTRL, {4'h9, nineMode, e[9], ovr, e[8]});
		rdChk(SCT_ADDR_RX_DATA, e[7:0]);
	endtask : popChk

	initial begin
		busReq = '0;
		reset_n = 1'b0;
		void'($urandom(65));
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rdChk(SCT_ADDR_TX_CTRL, 8'h01);
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h00);
		rdChk(3'h7, 8'h00);
		cmpPin(serialOutput, 1'b1);
		$display("test reset done");

		wr(SCT_ADDR_RX_CTRL, 8'h90);
		wr(SCT_ADDR_TX_CTRL, 8'h08);
		wr(SCT_ADDR_IRQ_GATE, 8'h03);
		wr(SCT_ADDR_IRQ_FLAG, 8'h02);
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h01);
		cmpPin(txIrq, 1'b0);
		wr(SCT_ADDR_IRQ_EN, 8'h01);
		step(2);
		cmpPin(txIrq, 1'b1);
		cmpPin(serialOutputEnable, 1'b1);
		$display("test enable done");

		for (int i = 0; i < 2; i++) begin
			b = 8'($urandom);
			expTx.push_back({1'b0, b});
			wr(SCT_ADDR_TX_HOLD, b);
			step(3);
		end
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h00);
		cmpPin(txIrq, 1'b0);
		wr(SCT_ADDR_IRQ_EN, 8'h00);
		rdChk(SCT_ADDR_TX_CTRL, 8'h08);
		waitGot(2);
		rdChk(SCT_ADDR_TX_CTRL, 8'h09);
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h01);
		nineMode = 1'b1;
		wr(SCT_ADDR_TX_CTRL, 8'h0E);
		b = 8'($urandom);
		expTx.push_back({1'b1, b});
		wr(SCT_ADDR_TX_HOLD, b);
		waitGot(3);
		nineMode = 1'b0;
		wr(SCT_ADDR_TX_CTRL, 8'h08);
		foreach (expTx[i]) cmpSer(u_peer.got[i], expTx[i]);
		wr(SCT_ADDR_TX_CTRL, 8'h18);
		step(1);
		cmpPin(serialOutput, 1'b0);
		rdChk(SCT_ADDR_TX_CTRL, 8'h19);
		wr(SCT_ADDR_TX_CTRL, 8'h08);
		$display("test transmit done");

		wr(SCT_ADDR_IRQ_EN, 8'h02);
		u_peer.glitch();
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h01);
		for (int i = 0; i < 4; i++) peerSend({1'b0, 8'($urandom)}, i != 1);
		step(4);
		cmpPin(rxIrq, 1'b1);
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h03);
		popChk();
		popChk();
		rdChk(SCT_ADDR_IRQ_FLAG, 8'h01);
		cmpPin(rxIrq, 1'b0);
		wr(SCT_ADDR_RX_CTRL, 8'h80);
		wr(SCT_ADDR_RX_CTRL, 8'h90);
		ovr = 1'b0;
		rdChk(SCT_ADDR_RX_CTRL, 8'h90);
		peerSend({1'b0, 8'($urandom)}, 1'b1);
		popChk();
		nineMode = 1'b1;
		wr(SCT_ADDR_RX_CTRL, 8'h98);
		peerSend({1'b1, 8'($urandom)}, 1'b1);
		popChk();
		nineMode = 1'b0;
		$display("test receive done");
		final_report();
	end
endmodule : tb
